/* hdl/xdata_steer_pkg.sv */
package xdata_steer_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0]  OFFS_SYSCTL   = 8'h00;  // system_control_reg
  localparam logic [7:0]  OFFS_PAGE     = 8'h04;  // page_high_byte_reg
  localparam logic [7:0]  OFFS_PTRSEL   = 8'h08;  // pointer_select_reg
  localparam logic [7:0]  OFFS_PTRVAL   = 8'h0C;  // Contents of the selected data_pointer
  localparam logic [7:0]  OFFS_STATUS   = 8'h10;  // Last routing decision
  localparam logic [7:0]  OFFS_LASTADDR = 8'h14;  // Last effective address

  // Field positions in system_control_reg
  localparam int          BIT_DISABLE   = 0;      // onchip_access_disable
  localparam int          BIT_VISIBLE   = 1;      // onchip_access_visible

  // Field positions in the status register
  localparam int          BIT_ST_ONCHIP = 0;
  localparam int          BIT_ST_LOWBUS = 1;
  localparam int          BIT_ST_HIGHBUS = 2;
  localparam int          BIT_ST_STROBE = 3;

  // Values after reset
  localparam logic        DISABLE_RST   = 1'b1;
  localparam logic        VISIBLE_RST   = 1'b0;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  localparam logic [2:0]  PTRSEL_RST    = 3'h0;
  localparam logic [15:0] PTR_RST       = 16'h0000;

  // On-chip RAM/CAN window
  localparam logic [15:0] ONCHIP_BASE   = 16'hF700;
  localparam logic [7:0]  ONCHIP_PAGE   = 8'hF7;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // Kind of external move, one-hot
  typedef enum logic [1:0] {
    KIND_POINTER = 2'b01,  // 16-bit pointer indirect
    KIND_PAGE    = 2'b10   // 8-bit indirect with page byte
  } move_kind_t;

  // Routing decision for one external move
  typedef struct packed {
    logic onchip;    // On-chip RAM/CAN used
    logic low_bus;   // low_addr_data_port in bus mode
    logic high_bus;  // high_addr_port in bus mode
    logic strobe;    // Read/write strobes active
  } route_t;

  // Decide routing from the map bits, the program-select pin and the range test
  function automatic route_t decide_route(input logic is_page,
                                          input logic in_range,
                                          input logic disable_bit,
                                          input logic visible_bit,
                                          input logic ext_prog);
    route_t r;
    r = '0;
    if (disable_bit || !in_range) begin
      r.onchip   = 1'b0;
      r.low_bus  = 1'b1;
      r.high_bus = !is_page;
      r.strobe   = 1'b1;
    end else begin
      r.onchip   = 1'b1;
      r.strobe   = visible_bit;
      r.low_bus  = visible_bit || !ext_prog;
      r.high_bus = !is_page && (visible_bit || !ext_prog);
    end
    return r;
  endfunction : decide_route

endpackage : xdata_steer_pkg

/* hdl/data_pointer_bank.sv */
`timescale 1ns/1ns
// Bank of selectable 16-bit data pointers; only the addressed one changes
module data_pointer_bank
  import xdata_steer_pkg::*;
#(
  parameter int NUM_PTR = 8,
  parameter int SEL_W   = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_en_i,
  input  wire logic [SEL_W-1:0] wr_sel_i,
  input  wire logic [15:0]      wr_data_i,
  input  wire logic [1:0]       wr_strb_i,
  input  wire logic [SEL_W-1:0] rd_sel_i,
  output logic      [15:0]      rd_data_o
);

  // Pointer storage, one word per pointer
  logic [15:0] ptr_mem [NUM_PTR];

  // One write port per pointer; others hold their value
  for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ptr_mem[g] <= PTR_RST;
      end else if (wr_en_i && (wr_sel_i == SEL_W'(g))) begin  // [RULE_10]
        if (wr_strb_i[0]) begin
          ptr_mem[g][7:0] <= wr_data_i[7:0];
        end
        if (wr_strb_i[1]) begin
          ptr_mem[g][15:8] <= wr_data_i[15:8];
        end
      end
    end
  end

  // Selected pointer out
  assign rd_data_o = ptr_mem[rd_sel_i];  // [RULE_11]

endmodule : data_pointer_bank

/* hdl/xdata_access_steering.sv */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
// Operation
// [RULE_01] Pointer below window: external, both ports bus, strobes
// [RULE_02] Page below window: external, low bus, high I/O
// [RULE_03] Map 00, pin low, pointer: on-chip, bus, no strobes
// [RULE_04] Map 00, pin high: on-chip, ports I/O, no strobes
// [RULE_05] Map 00, pin low, page: on-chip, low bus only
// [RULE_06] Visible, pointer in window: on-chip, bus, strobes active
// [RULE_07] Visible, page in window: on-chip, low bus, strobes
// [RULE_08] Disable set: every move external with strobes
// [RULE_09] Eight independent 16-bit data pointers
// [RULE_10] Only the selected pointer is used or changed
// [RULE_11] Pointer select register chooses the active pointer
// [RULE_12] Pointer in window means F700 to FFFF
// [RULE_13] Page register supplies address bits 8 to 15
// [RULE_14] Disable bit set by reset, never by software
// [RULE_15] Disable set routes all moves to external bus
// [RULE_16] Page F7 or above counts as in window
module xdata_access_steering
  import xdata_steer_pkg::*;
#(
  parameter int NUM_PTR = 8,
  parameter int SEL_W   = 3
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register bus, AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External move requests from the CPU core
  input  wire logic        move_req_i,
  input  wire move_kind_t  move_kind_i,
  input  wire logic [7:0]  move_low_addr_i,
  input  wire logic        external_program_select_i,
  // Routing result toward ports, strobes and on-chip RAM
  output logic             route_valid_o,
  output logic             route_onchip_o,
  output logic             low_addr_data_port_bus_o,
  output logic             high_addr_port_bus_o,
  output logic             strobes_active_o,
  output logic [15:0]      eff_addr_o
);

  // Control and state registers
  logic             disable_reg;       // onchip_access_disable
  logic             visible_reg;       // onchip_access_visible
  logic [7:0]       page_high_byte_reg;
  logic [SEL_W-1:0] pointer_select_reg;
  route_t           route_reg;         // Last decision
  logic             route_valid_reg;   // One-cycle result pulse
  logic [15:0]      eff_addr_reg;

  // Write channel state
  logic             awready_reg;
  logic             wready_reg;
  logic             aw_have_reg;
  logic             w_have_reg;
  logic [7:0]       waddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;

  // Read channel state
  logic             arready_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  // Shared decode
  logic             wr_fire;           // Both halves of a write held
  logic [15:0]      ptr_value;         // Active pointer contents
  logic             ptr_wr_en;
  logic [15:0]      move_addr;         // Effective address of the move
  logic             move_is_page;
  logic             move_in_range;
  route_t           route_next;

  // Address is mapped when it hits one of the six words
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == OFFS_SYSCTL) || (a == OFFS_PAGE) || (a == OFFS_PTRSEL) ||
           (a == OFFS_PTRVAL) || (a == OFFS_STATUS) || (a == OFFS_LASTADDR);
  endfunction : addr_mapped

  // A write fires once address and data are both held and no answer waits;
  // the held copies let the two channels arrive in either order
  assign wr_fire   = aw_have_reg && w_have_reg && !bvalid_reg;
  // Only the pointer word reaches the bank, so other words never disturb it
  assign ptr_wr_en = wr_fire && (waddr_reg == OFFS_PTRVAL);

  // Pointer bank; writes reach only the selected pointer
  data_pointer_bank #(
    .NUM_PTR (NUM_PTR),
    .SEL_W   (SEL_W)
  ) u_ptr_bank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (ptr_wr_en),
    .wr_sel_i  (pointer_select_reg),  // [RULE_10]
    .wr_data_i (wdata_reg[15:0]),
    .wr_strb_i (wstrb_reg[1:0]),
    .rd_sel_i  (pointer_select_reg),  // [RULE_11]
    .rd_data_o (ptr_value)
  );  // [RULE_09]

  // Effective address and range test for the move being requested
  always_comb begin
    move_is_page = (move_kind_i == KIND_PAGE);
    if (move_is_page) begin
      move_addr     = {page_high_byte_reg, move_low_addr_i};  // [RULE_13]
      move_in_range = (page_high_byte_reg >= ONCHIP_PAGE);    // [RULE_16]
    end else begin
      move_addr     = ptr_value;                              // [RULE_11]
      move_in_range = (ptr_value >= ONCHIP_BASE);             // [RULE_12]
    end
    // Below window goes out on the bus: [RULE_01] [RULE_02]
    // Disable forces the external bus: [RULE_08] [RULE_15]
    // On-chip modes by map bits and pin: [RULE_03] [RULE_04] [RULE_05]
    // Visible on-chip modes: [RULE_06] [RULE_07]
    route_next = decide_route(move_is_page, move_in_range, disable_reg,
                              visible_reg, external_program_select_i);
  end

  // Latch routing for each request; result stands until the next request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_reg       <= '0;
      eff_addr_reg    <= 16'h0000;
      route_valid_reg <= 1'b0;
    end else begin
      route_valid_reg <= move_req_i;
      if (move_req_i) begin
        route_reg    <= route_next;  // [RULE_01] [RULE_08]
        eff_addr_reg <= move_addr;   // [RULE_13]
      end
    end
  end

  // Map bits; the disable bit can only be cleared by software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disable_reg <= DISABLE_RST;  // [RULE_14]
      visible_reg <= VISIBLE_RST;
    end else if (wr_fire && (waddr_reg == OFFS_SYSCTL) && wstrb_reg[0]) begin
      // Writing one keeps it as is; once cleared, only reset returns it to one
      disable_reg <= disable_reg && wdata_reg[BIT_DISABLE];  // [RULE_14]
      visible_reg <= wdata_reg[BIT_VISIBLE];
    end
  end

  // Page byte register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_high_byte_reg <= PAGE_RST;
    end else if (wr_fire && (waddr_reg == OFFS_PAGE) && wstrb_reg[0]) begin
      page_high_byte_reg <= wdata_reg[7:0];  // [RULE_13]
    end
  end

  // Pointer select register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pointer_select_reg <= PTRSEL_RST;
    end else if (wr_fire && (waddr_reg == OFFS_PTRSEL) && wstrb_reg[0]) begin
      pointer_select_reg <= wdata_reg[SEL_W-1:0];  // [RULE_11]
    end
  end

  // Write address channel; held until the answer is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      waddr_reg   <= 8'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      // Address taken; refuse another until the answer is accepted
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      waddr_reg   <= s_axi_awaddr;
    end else if (wr_fire) begin
      // Held address consumed by the write
      aw_have_reg <= 1'b0;
    end else if (!aw_have_reg && !bvalid_reg) begin
      // Idle again once the answer has gone
      awready_reg <= 1'b1;
    end
  end

  // Write data channel; may arrive before or after the address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      // Data taken; held until the address is also here
      wready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      // Held data consumed by the write
      w_have_reg <= 1'b0;
    end else if (!w_have_reg && !bvalid_reg) begin
      // Reopen only with no answer pending, so one write at a time
      wready_reg <= 1'b1;
    end
  end

  // Write response; read-only and unmapped words answer with an error
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      if (addr_mapped(waddr_reg) && (waddr_reg != OFFS_STATUS) &&
          (waddr_reg != OFFS_LASTADDR)) begin
        bresp_reg <= RESP_OKAY;
      end else begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      // Response taken; the write channels reopen next cycle
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; one word answered the cycle after the address is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFFS_SYSCTL: begin
          rdata_reg <= {30'h0, visible_reg, disable_reg};
        end
        OFFS_PAGE: begin
          rdata_reg <= {24'h00_0000, page_high_byte_reg};
        end
        OFFS_PTRSEL: begin
          rdata_reg <= {{(32-SEL_W){1'b0}}, pointer_select_reg};
        end
        OFFS_PTRVAL: begin
          rdata_reg <= {16'h0000, ptr_value};  // [RULE_11]
        end
        OFFS_STATUS: begin
          rdata_reg <= {28'h000_0000, route_reg.strobe, route_reg.high_bus,
                        route_reg.low_bus, route_reg.onchip};
        end
        OFFS_LASTADDR: begin
          rdata_reg <= {16'h0000, eff_addr_reg};
        end
        default: begin
          // Unmapped word reads as zero
          rdata_reg <= 32'h0000_0000;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      // Answer accepted; the port reopens one cycle later
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      // Ready only with no answer pending, so one read at a time
      arready_reg <= 1'b1;
    end
  end

  // Outputs, all from flip-flops
  assign s_axi_awready            = awready_reg;
  assign s_axi_wready             = wready_reg;
  assign s_axi_bvalid             = bvalid_reg;
  assign s_axi_bresp              = bresp_reg;
  assign s_axi_arready            = arready_reg;
  assign s_axi_rvalid             = rvalid_reg;
  assign s_axi_rdata              = rdata_reg;
  assign s_axi_rresp              = rresp_reg;
  assign route_valid_o            = route_valid_reg;
  assign route_onchip_o           = route_reg.onchip;
  assign low_addr_data_port_bus_o = route_reg.low_bus;
  assign high_addr_port_bus_o     = route_reg.high_bus;
  assign strobes_active_o         = route_reg.strobe;
  assign eff_addr_o               = eff_addr_reg;

endmodule : xdata_access_steering

/* verification/ext_mem_model.sv */
`timescale 1ns/1ns
// Far-side memory: counts every strobed access that lands off chip
module ext_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        route_valid_i,
  input  wire logic        onchip_i,
  input  wire logic        strobe_i,
  output logic      [15:0] hits_o
);
  // Count only cycles with strobes, so a quiet on-chip move is never seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hits_o <= 16'h0000;
    end else if (route_valid_i && strobe_i && !onchip_i) begin
      hits_o <= hits_o + 16'h0001;
    end
  end
endmodule : ext_mem_model

/* verification/xdata_steer_sva.sv */
`timescale 1ns/1ns
module xdata_steer_sva
  import xdata_steer_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        move_req_i,
  input wire move_kind_t  move_kind_i,
  input wire logic [7:0]  move_low_addr_i,
  input wire logic        external_program_select_i,
  input wire logic        route_valid_o,
  input wire logic        route_onchip_o,
  input wire logic        low_addr_data_port_bus_o,
  input wire logic        high_addr_port_bus_o,
  input wire logic        strobes_active_o,
  input wire logic [15:0] eff_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic pg_q;   // Kind of the request answered this cycle
  logic pin_q;  // Program-select level of that request
  logic v, on, lo, hi, st;
  assign v  = route_valid_o;
  assign on = route_onchip_o;
  assign lo = low_addr_data_port_bus_o;
  assign hi = high_addr_port_bus_o;
  assign st = strobes_active_o;
  // Answer comes one edge later, so one stage of history is enough
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pg_q  <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      pg_q  <= (move_kind_i == KIND_PAGE);
      pin_q <= external_program_select_i;
    end
  end
  AST_PULSE: assert property (v == $past(move_req_i)) else $error("route pulse late");
  AST_HOLD: assert property (!$past(move_req_i) |-> $stable(eff_addr_o) && $stable(on))
    else $error("route changed without request");
  AST_PTR_LOW: assert property (v && !pg_q && eff_addr_o < ONCHIP_BASE
    |-> !on && lo && hi && st) else $error("pointer below window not external");
  AST_PAGE_LOW: assert property (v && pg_q && eff_addr_o[15:8] < ONCHIP_PAGE
    |-> !on && lo && !hi && st) else $error("page below window not external");
  AST_RANGE: assert property (v && on |->
    (pg_q ? eff_addr_o[15:8] >= ONCHIP_PAGE : eff_addr_o >= ONCHIP_BASE))
    else $error("on-chip outside window");
  AST_IO: assert property (v && on && !st && pin_q |-> !lo && !hi)
    else $error("ports not I/O");
  AST_QUIET: assert property (v && on && !st && !pin_q
    |-> lo && (hi == !pg_q)) else $error("quiet on-chip port use wrong");
  AST_VISIBLE: assert property (v && on && st |-> lo && (hi == !pg_q))
    else $error("visible on-chip port use wrong");
  AST_EXT: assert property (v && !on |-> st && lo && (hi == !pg_q))
    else $error("external access port use wrong");
  AST_PAGE_ADDR: assert property (v && pg_q
    |-> eff_addr_o[7:0] == $past(move_low_addr_i)) else $error("page low byte wrong");
  C_VIS: cover property (v && on && st);
  C_IO: cover property (v && on && !st && pin_q);
  C_EXT: cover property (v && !on);
endmodule : xdata_steer_sva

bind xdata_access_steering xdata_steer_sva chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .move_req_i(move_req_i), .move_kind_i(move_kind_i),
  .move_low_addr_i(move_low_addr_i), .external_program_select_i(external_program_select_i),
  .route_valid_o(route_valid_o), .route_onchip_o(route_onchip_o),
  .low_addr_data_port_bus_o(low_addr_data_port_bus_o),
  .high_addr_port_bus_o(high_addr_port_bus_o), .strobes_active_o(strobes_active_o),
  .eff_addr_o(eff_addr_o));

/* verification/xdata_access_steering_tb.sv */
`timescale 1ns/1ns
module xdata_access_steering_tb;
  import xdata_steer_pkg::*;
  logic        clk_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, move_req_i, external_program_select_i;
  logic        route_valid_o, route_onchip_o, low_addr_data_port_bus_o;
  logic        high_addr_port_bus_o, strobes_active_o, dis, vis;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, move_low_addr_i, page;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] eff_addr_o, ext_hits, last_ea, ptrs [8];
  logic [2:0]  sel;
  logic [3:0]  last_e;
  move_kind_t  move_kind_i;
  int          error_cnt, n_tests, n_ext, seed;

  xdata_access_steering uut (.*);
  ext_mem_model mem_i (.clk_i(clk_i), .rst_i(rst_i), .route_valid_i(route_valid_o),
    .onchip_i(route_onchip_o), .strobe_i(strobes_active_o), .hits_o(ext_hits));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Both channels offered together; bready up early so bvalid is taken at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int   n;
    {aw, w, b} = 3'b111;
    n = 0;
    // Start one edge on, so a handshake just dropped is never raised in the same step
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (b) begin
      @(posedge clk_i);
      if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 1'b0; end
      if (s_axi_bvalid) begin b = 0; rsp = s_axi_bresp; s_axi_bready <= 1'b0; end
      if (++n == 50) begin error_cnt++; conclude(); end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    int   n;
    {ar, r} = 2'b11;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (r) begin
      @(posedge clk_i);
      if (ar && s_axi_arready) begin ar = 0; s_axi_arvalid <= 1'b0; end
      if (s_axi_rvalid) begin r = 0; rd = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 1'b0; end
      if (++n == 50) begin error_cnt++; conclude(); end
    end
  endtask : axi_rd

  // Expected {strobe, high, low, onchip} for one move
  function automatic logic [3:0] exp_rt(input logic pg, input logic [15:0] ea,
                                         input logic pin);
    logic inr;
    inr = pg ? (ea[15:8] >= 8'hF7) : (ea >= 16'hF700);
    // One entry of the routing table per case, written out
    if (dis || !inr) return pg ? 4'b1010 : 4'b1110;
    if (vis) return pg ? 4'b1011 : 4'b1111;
    if (pin) return 4'b0001;
    return pg ? 4'b0011 : 4'b0111;
  endfunction : exp_rt

  // One move request, answer checked in the cycle it stands
  task automatic mv(input logic pg, input logic [7:0] lo, input logic pin);
    logic [15:0] ea;
    logic [3:0]  e;
    ea = pg ? {page, lo} : ptrs[sel];
    e = exp_rt(pg, ea, pin);
    n_ext += (e[3] && !e[0]) ? 1 : 0;
    move_req_i <= 1'b1;
    move_kind_i <= pg ? KIND_PAGE : KIND_POINTER;
    move_low_addr_i <= lo;
    external_program_select_i <= pin;
    @(posedge clk_i);
    move_req_i <= 1'b0;
    // route_valid_o stands only for the cycle after the request edge; the routing outputs hold until the next request
    #1;
    last_e = e;
    last_ea = ea;
    chk("route_valid", 32'(route_valid_o), 32'h1);
    chk("onchip", 32'(route_onchip_o), 32'(e[0]));
    chk("low_bus", 32'(low_addr_data_port_bus_o), 32'(e[1]));
    chk("high_bus", 32'(high_addr_port_bus_o), 32'(e[2]));
    chk("strobes", 32'(strobes_active_o), 32'(e[3]));
    chk("eff_addr", 32'(eff_addr_o), 32'(ea));
  endtask : mv

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {move_req_i, external_program_select_i, move_low_addr_i} = 10'h000;
    move_kind_i = KIND_POINTER;
    rst_i = 1'b1;
    {dis, vis, page, sel, error_cnt, n_tests, n_ext} = '0;
    dis = 1'b1;
    seed = $urandom(32'h9389);
    do_reset();
    axi_rd(OFFS_SYSCTL);
    chk("sysctl", rd, 32'h0000_0001);
    axi_rd(OFFS_PTRVAL);
    chk("ptr_rst", rd, 32'h0000_0000);
    axi_rd(8'h20);
    chk("unmapped", 32'(rsp), 32'(RESP_SLVERR));
    axi_wr(OFFS_STATUS, 32'h0000_000F);
    chk("ro_write", 32'(rsp), 32'(RESP_SLVERR));
    // Window edges in the first three pointers, the rest random
    for (int i = 0; i < 8; i++) begin
      ptrs[i] = (i == 0) ? 16'hF700 : (i == 1) ? 16'hF6FF : (i == 2) ? 16'hFFFF : 16'($urandom);
      axi_wr(OFFS_PTRSEL, 32'(i));
      axi_wr(OFFS_PTRVAL, 32'(ptrs[i]));
    end
    for (int i = 0; i < 8; i++) begin
      axi_wr(OFFS_PTRSEL, 32'(i));
      axi_rd(OFFS_PTRVAL);
      chk("ptr", rd, 32'(ptrs[i]));
    end
    // Disable first, then enabled with random visibility; bit0 writes of 1 must not stick
    for (int k = 0; k < 60; k++) begin
      if (k == 12) begin
        axi_wr(OFFS_SYSCTL, 32'h0000_0000);
        axi_wr(OFFS_SYSCTL, 32'h0000_0001);
        dis = 1'b0;
        axi_rd(OFFS_SYSCTL);
        chk("sysctl", rd, 32'h0000_0000);
      end
      if (k > 12 && k % 4 == 0) begin
        vis = 1'($urandom);
        axi_wr(OFFS_SYSCTL, {30'h0, vis, 1'b1});
      end
      sel = 3'($urandom);
      page = (k % 3 == 0) ? {7'h7B, k[0]} : 8'($urandom);
      axi_wr(OFFS_PTRSEL, 32'(sel));
      axi_wr(OFFS_PAGE, 32'(page));
      mv(1'($urandom), 8'($urandom), 1'($urandom));
      if (k % 5 == 0) begin
        axi_rd(OFFS_STATUS);
        chk("status", rd, 32'(last_e));
        axi_rd(OFFS_LASTADDR);
        chk("last_addr", rd, 32'(last_ea));
      end
    end
    // Low byte only: the selected pointer's high byte must survive
    s_axi_wstrb <= 4'h1;
    axi_wr(OFFS_PTRVAL, 32'h0000_ABCD);
    s_axi_wstrb <= 4'hF;
    axi_rd(OFFS_PTRVAL);
    chk("ptr_strb", rd, {16'h0000, ptrs[sel][15:8], 8'hCD});
    chk("ext_hits", 32'(ext_hits), 32'(n_ext));
    do_reset();
    axi_rd(OFFS_SYSCTL);
    chk("sysctl", rd, 32'h0000_0001);
    conclude();
  end
endmodule : xdata_access_steering_tb
